// ### rtl/ccb_compat_config_bank.sv
// Compatible configuration and status register bank behind the I/O bus
`timescale 1ns/1ns

module ccb_compat_config_bank
(
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    srst_in,
  // I/O bus
  input  wire logic [ccb_pkg::ADDR_W-1:0] io_addr_in,
  input  wire logic                    io_rd_in,
  input  wire logic                    io_wr_in,
  input  wire logic                    io_word_in,
  input  wire logic [15:0]             io_wr_data_in,
  output logic      [15:0]             io_rd_data_out,
  output logic                         io_rd_valid_out,
  // Board context
  input  wire logic                    register_bank_select_in,
  input  wire logic                    ten_bit_decode_in,
  input  wire logic                    source_status_bank_enable_in,
  input  wire ccb_pkg::ccb_jumpers_t   jumpers_in,
  input  wire ccb_pkg::ccb_events_t    events_in,
  // Control outputs
  output logic                         burst_mode_enabled_out,
  output logic                         compat_functions_on_out,
  output logic                         conversions_allowed_out,
  output logic                         index_autoinc_off_out,
  output logic                         fifo_reset_out,
  output logic                         irq_source_a_flag_out,
  output logic                         irq_source_b_flag_out
);
  import ccb_pkg::*;

  ccb_state_t st_r;
  ccb_state_t st_nxt;

  // Event picked by a four-bit source code
  function automatic logic src_hit(input logic [3:0] code,
                                   input ccb_events_t ev,
                                   input logic [3:0] rise,
                                   input logic [3:0] fall);
    logic hit;
    hit = 1'b0;
    if (code[3])
    begin
      hit = code[0] ? fall[code[2:1]] : rise[code[2:1]];
    end
    else
    begin
      unique case (code)
        SRC_THRESHOLD: hit = ev.threshold;
        SRC_FRAME_MAX: hit = ev.frame_max;
        SRC_TRIG_ON:   hit = ev.trig_start;
        SRC_TRIG_OFF:  hit = ev.trig_stop;
        default:       hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // Read value of one byte of the indexed array
  function automatic logic [7:0] rd_byte(input ccb_state_t s,
                                         input logic [7:0] idx,
                                         input ccb_jumpers_t j);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_GEN_CONFIG: v = {s.index_autoinc_off, j};
      IDX_IRQ_SELECT: v = s.irq_select;
      IDX_EXT_STATUS: v = {1'b0, s.burst_mode_enabled, s.compat_functions_on,
                           s.conversions_allowed, 2'b00,
                           1'b0,
                           ~j.clock_rate_jumper};
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  // Whether an index is reachable through the data port
  function automatic logic idx_mapped(input logic [7:0] idx, input logic ten_bit);
    logic m;
    m = 1'b0;
    unique case (idx)
      IDX_GEN_CONFIG,
      IDX_IRQ_SELECT:   m = 1'b1;
      IDX_CONV_DISABLE,
      IDX_BURST_ENABLE,
      IDX_FUNC_ENABLE,
      IDX_EXT_STATUS:   m = ten_bit;
      default:          m = 1'b0;
    endcase
    return m;
  endfunction

  logic       hit_direct;
  logic       hit_ptr;
  logic       hit_data;
  logic [7:0] base_idx;
  logic [3:0] din_rise;
  logic [3:0] din_fall;

  // Direct compatible offsets map onto the same indices, whatever the bank bit
  assign hit_direct = (io_addr_in[ADDR_W-1:2] == OFS_CONV_DISABLE[ADDR_W-1:2]);
  assign hit_ptr    = (io_addr_in == OFS_INDEX_POINTER);
  assign hit_data   = (io_addr_in == OFS_INDEX_DATA) && register_bank_select_in;
  assign base_idx   = hit_direct ? {IDX_CONV_DISABLE[7:2], io_addr_in[1:0]}
                                 : st_r.index_ptr;
  assign din_rise   = events_in.digital_in & ~st_r.din_prev;
  assign din_fall   = ~events_in.digital_in & st_r.din_prev;

  always_comb
  begin
    logic [7:0] idx;
    logic [7:0] wb;
    logic       lane_ok;
    logic [1:0] n_bytes;
    idx     = 8'h00;
    wb      = 8'h00;
    lane_ok = 1'b0;
    n_bytes = io_word_in ? 2'd2 : 2'd1;
    st_nxt  = st_r;
    st_nxt.rd_valid   = 1'b0;
    st_nxt.fifo_reset = 1'b0;
    st_nxt.din_prev   = events_in.digital_in;

    // Flags only count while the status bank shows the sources
    st_nxt.src_a_hit = source_status_bank_enable_in &&
                       src_hit(st_r.irq_select[IS_A_MSB:IS_A_LSB], events_in,
                               din_rise, din_fall);
    st_nxt.src_b_hit = source_status_bank_enable_in &&
                       src_hit(st_r.irq_select[IS_B_MSB:IS_B_LSB], events_in,
                               din_rise, din_fall);

    if (io_wr_in && hit_ptr)
    begin
      st_nxt.index_ptr = io_wr_data_in[7:0];
    end
    else if (io_rd_in && hit_ptr)
    begin
      st_nxt.rd_data  = {8'h00, st_r.index_ptr};
      st_nxt.rd_valid = 1'b1;
    end
    else if ((io_wr_in || io_rd_in) && (hit_direct || hit_data))
    begin
      // Direct offsets are byte wide; the data port may move a word
      for (int lane = 0; lane < 2; lane++)
      begin
        idx     = base_idx + 8'(lane);
        wb      = io_wr_data_in[lane*8 +: 8];
        lane_ok = (lane == 0) || (io_word_in && hit_data);
        if (hit_data)
        begin
          lane_ok = lane_ok && idx_mapped(idx, ten_bit_decode_in);
        end
        if (io_rd_in)
        begin
          st_nxt.rd_data[lane*8 +: 8] = lane_ok ? rd_byte(st_r, idx, jumpers_in) : 8'h00;
        end
        else if (lane_ok)
        begin
          unique case (idx)
            IDX_GEN_CONFIG:
              st_nxt.index_autoinc_off = wb[GC_AUTOINC_OFF_BIT];
            IDX_IRQ_SELECT:
              st_nxt.irq_select = wb;
            IDX_CONV_DISABLE:
              if (st_r.compat_functions_on)
              begin
                if (wb == CMD_OFF)
                begin
                  st_nxt.conversions_allowed = 1'b1;
                end
                else if (wb == CMD_ON)
                begin
                  st_nxt.conversions_allowed = 1'b0;
                  st_nxt.fifo_reset = ~jumpers_in.mode_jumper_one;
                end
              end
            IDX_BURST_ENABLE:
              if (st_r.compat_functions_on)
              begin
                if (wb == CMD_ON)
                begin
                  st_nxt.burst_mode_enabled = 1'b1;
                end
                else if (wb == CMD_OFF)
                begin
                  st_nxt.burst_mode_enabled = 1'b0;
                end
              end
            IDX_FUNC_ENABLE:
              if (wb == CMD_ON)
              begin
                st_nxt.compat_functions_on = 1'b1;
              end
              else if (wb == CMD_OFF)
              begin
                st_nxt.compat_functions_on = 1'b0;
              end
            default:
              st_nxt.irq_select = st_nxt.irq_select;
          endcase
        end
      end
      st_nxt.rd_valid = io_rd_in;
      // Pointer moves even on unmapped bytes, so block transfers stay aligned
      if (hit_data && !st_r.index_autoinc_off)
      begin
        st_nxt.index_ptr = st_r.index_ptr + {6'h00, n_bytes};
      end
    end
    else if (io_rd_in)
    begin
      // Unmapped reads answer zero rather than hang the bus
      st_nxt.rd_data  = 16'h0000;
      st_nxt.rd_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      st_r                     <= '0;
      st_r.burst_mode_enabled  <= 1'b0;
      st_r.compat_functions_on <= 1'b0;
      st_r.conversions_allowed <= 1'b1;
      st_r.irq_select          <= RST_IRQ_SELECT;
      st_r.index_ptr           <= RST_INDEX;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign io_rd_data_out          = st_r.rd_data;
  assign io_rd_valid_out         = st_r.rd_valid;
  assign burst_mode_enabled_out  = st_r.burst_mode_enabled;
  assign compat_functions_on_out = st_r.compat_functions_on;
  assign conversions_allowed_out = st_r.conversions_allowed;
  assign index_autoinc_off_out   = st_r.index_autoinc_off;
  assign fifo_reset_out          = st_r.fifo_reset;
  assign irq_source_a_flag_out   = st_r.src_a_hit;
  assign irq_source_b_flag_out   = st_r.src_b_hit;

endmodule

// ### rtl/ccb_pkg.sv
// Package for the compatible configuration register bank: map, fields, resets, types
package ccb_pkg;

  // Bus and index widths
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned IDX_W  = 8;

  // Direct I/O offsets
  localparam logic [10:0] OFS_CONV_DISABLE  = 11'h404;
  localparam logic [10:0] OFS_BURST_ENABLE  = 11'h405;
  localparam logic [10:0] OFS_FUNC_ENABLE   = 11'h406;
  localparam logic [10:0] OFS_EXT_STATUS    = 11'h407;
  localparam logic [10:0] OFS_INDEX_POINTER = 11'h00E;
  localparam logic [10:0] OFS_INDEX_DATA    = 11'h00F;

  // Byte indices in the indexed array
  localparam logic [7:0] IDX_GEN_CONFIG   = 8'h00;
  localparam logic [7:0] IDX_IRQ_SELECT   = 8'h02;
  localparam logic [7:0] IDX_CONV_DISABLE = 8'h40;
  localparam logic [7:0] IDX_BURST_ENABLE = 8'h41;
  localparam logic [7:0] IDX_FUNC_ENABLE  = 8'h42;
  localparam logic [7:0] IDX_EXT_STATUS   = 8'h43;

  // Enable and disable command values
  localparam logic [7:0] CMD_ON  = 8'h40;
  localparam logic [7:0] CMD_OFF = 8'h00;

  // Field positions
  localparam int unsigned GC_AUTOINC_OFF_BIT = 7;
  localparam int unsigned JMP_M1_BIT         = 1;
  localparam int unsigned JMP_CLOCK_BIT      = 6;
  localparam int unsigned IS_B_MSB           = 7;
  localparam int unsigned IS_B_LSB           = 4;
  localparam int unsigned IS_A_MSB           = 3;
  localparam int unsigned IS_A_LSB           = 0;

  // Reset values
  localparam logic [7:0] RST_IRQ_SELECT = 8'h00;
  localparam logic [7:0] RST_INDEX      = 8'h00;

  // Interrupt source codes
  localparam logic [3:0] SRC_NONE      = 4'h0;
  localparam logic [3:0] SRC_THRESHOLD = 4'h2;
  localparam logic [3:0] SRC_FRAME_MAX = 4'h3;
  localparam logic [3:0] SRC_TRIG_ON   = 4'h4;
  localparam logic [3:0] SRC_TRIG_OFF  = 4'h5;

  // Event sources seen by the block
  typedef struct packed {
    logic       threshold;
    logic       frame_max;
    logic       trig_start;
    logic       trig_stop;
    logic [3:0] digital_in;
  } ccb_events_t;

  // Board jumpers: [4:0] mode, [5] transfer or fifth, [6] clock rate
  typedef struct packed {
    logic clock_rate_jumper;
    logic transfer_or_fifth_jumper;
    logic mode_jumper_four;
    logic mode_jumper_three;
    logic mode_jumper_two;
    logic mode_jumper_one;
    logic mode_jumper_zero;
  } ccb_jumpers_t;

  // Whole state of the bank
  typedef struct packed {
    logic        burst_mode_enabled;
    logic        compat_functions_on;
    logic        conversions_allowed;
    logic        index_autoinc_off;
    logic [7:0]  irq_select;
    logic [7:0]  index_ptr;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [3:0]  din_prev;
    logic        src_a_hit;
    logic        src_b_hit;
    logic        fifo_reset;
  } ccb_state_t;

endpackage

// ### tb/ccb_host.sv
// Host model driving the I/O bus of the register bank
`timescale 1ns/1ns
module ccb_host
(
  // Bus
  input  wire logic        clk_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  output logic      [10:0] addr_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic             word_out,
  output logic      [15:0] wr_data_out
);
  initial {addr_out, rd_out, wr_out, word_out, wr_data_out} = '0;

  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic w);
    @(negedge clk_in);
    {addr_out, wr_data_out, word_out, wr_out} = {a, d, w, 1'b1};
    @(negedge clk_in);
    {addr_out, wr_data_out, wr_out} = {~a, ~d, 1'b0};
  endtask

  task automatic rd(input logic [10:0] a, input logic w, output logic [15:0] d);
    @(negedge clk_in);
    {addr_out, word_out, rd_out} = {a, w, 1'b1};
    @(negedge clk_in);
    d = rd_valid_in ? rd_data_in : 16'hXXXX;
    {addr_out, rd_out} = {~a, 1'b0};
  endtask
endmodule

// ### tb/ccb_chk.sv
// Port checker for the compatible configuration register bank
`timescale 1ns/1ns
module ccb_chk
  import ccb_pkg::*;
(
  // Watched ports
  input wire logic              ref_clk_in,
  input wire logic              srst_in,
  input wire logic [ADDR_W-1:0] io_addr_in,
  input wire logic              io_rd_in,
  input wire logic              io_wr_in,
  input wire logic [15:0]       io_wr_data_in,
  input wire logic [15:0]       io_rd_data_out,
  input wire logic              io_rd_valid_out,
  input wire ccb_jumpers_t      jumpers_in,
  input wire logic              burst_mode_enabled_out,
  input wire logic              compat_functions_on_out,
  input wire logic              conversions_allowed_out,
  input wire logic              fifo_reset_out
);
  logic [7:0] wd, st_exp_r;
  logic       bu, fe, ca, fe_w, bu_w, cd_w, st_r;
  assign {bu, fe, ca} = {burst_mode_enabled_out, compat_functions_on_out, conversions_allowed_out};
  assign wd   = io_wr_data_in[7:0];
  assign fe_w = io_wr_in && io_addr_in == OFS_FUNC_ENABLE;
  assign bu_w = io_wr_in && io_addr_in == OFS_BURST_ENABLE;
  assign cd_w = io_wr_in && io_addr_in == OFS_CONV_DISABLE && wd == CMD_ON;
  assign st_r = io_rd_in && io_addr_in == OFS_EXT_STATUS;
  always_ff @(posedge ref_clk_in)
    st_exp_r <= {1'b0, bu, fe, ca, 3'b000, ~jumpers_in.clock_rate_jumper};
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  reset_vals_a: assert property ($fell(srst_in) |-> !bu && !fe && ca)
    else $error("bad state after reset");
  rd_pulse_a: assert property (io_rd_in |=> io_rd_valid_out)
    else $error("read valid missing");
  rd_idle_a: assert property (!io_rd_in |=> !io_rd_valid_out)
    else $error("read valid without read");
  status_a: assert property (st_r |=> io_rd_data_out[7:0] == st_exp_r)
    else $error("status byte wrong");
  burst_gate_a: assert property (bu_w && !fe |=> $stable(bu))
    else $error("burst changed while functions off");
  burst_on_a: assert property (bu_w && fe && wd == CMD_ON |=> bu)
    else $error("burst not enabled");
  burst_off_a: assert property (bu_w && fe && wd == CMD_OFF |=> !bu)
    else $error("burst not disabled");
  func_on_a: assert property (fe_w && wd == CMD_ON |=> fe)
    else $error("functions not enabled");
  func_keep_a: assert property (fe_w && wd != CMD_ON && wd != CMD_OFF |=> $stable(fe))
    else $error("functions changed by odd value");
  fifo_rst_a: assert property (cd_w && fe && !jumpers_in.mode_jumper_one |=> fifo_reset_out)
    else $error("fifo reset missing");

  cover property (bu_w && fe && wd == CMD_ON);
  cover property (fifo_reset_out);
  cover property (st_r && fe);
endmodule

// ### tb/tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
module tb;
  import ccb_pkg::*;
  logic         ref_clk_in, srst_in, io_rd_in, io_wr_in, io_word_in, io_rd_valid_out;
  logic         bank, ten, ssbe, bu, fe, ca, ai, fr, fa, fb, eb, ef, ec, nz, s;
  logic [10:0]  io_addr_in;
  logic [15:0]  io_wr_data_in, io_rd_data_out, v;
  logic [7:0]   c8;
  logic [3:0]   c;
  ccb_jumpers_t jmp;
  ccb_events_t  ev, e;
  logic [7:0]   cmd [6] = '{8'h55, 8'h40, 8'h41, 8'hC0, 8'h00, 8'h40};
  int           fail_count, num_checks, seed, i;

  ccb_compat_config_bank i_ccb_compat_config_bank (.ref_clk_in, .srst_in, .io_addr_in,
    .io_rd_in, .io_wr_in, .io_word_in, .io_wr_data_in, .io_rd_data_out, .io_rd_valid_out,
    .register_bank_select_in(bank), .ten_bit_decode_in(ten),
    .source_status_bank_enable_in(ssbe), .jumpers_in(jmp), .events_in(ev),
    .burst_mode_enabled_out(bu), .compat_functions_on_out(fe), .conversions_allowed_out(ca),
    .index_autoinc_off_out(ai), .fifo_reset_out(fr), .irq_source_a_flag_out(fa),
    .irq_source_b_flag_out(fb));
  ccb_host i_ccb_host (.clk_in(ref_clk_in), .rd_data_in(io_rd_data_out),
    .rd_valid_in(io_rd_valid_out), .addr_out(io_addr_in), .rd_out(io_rd_in),
    .wr_out(io_wr_in), .word_out(io_word_in), .wr_data_out(io_wr_data_in));

  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [7:0] st();
    return {1'b0, eb, ef, ec, 3'b000, ~jmp.clock_rate_jumper};
  endfunction

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic sc();
    i_ccb_host.rd(OFS_EXT_STATUS, 1'b0, v);
    chk("status", {8'h00, st()}, v);
  endtask

  task automatic idx(input logic [7:0] x);
    i_ccb_host.wr(OFS_INDEX_POINTER, {8'h00, x}, 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    fail_count++;
    print_verdict();
  end

  initial
  begin
    seed = 32'hD3FB32D9;
    {srst_in, bank, ten, ssbe, jmp, ev, eb, ef, ec} = {4'h9, 15'h0000, 3'b001};
    repeat (10) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    srst_in = 1'b0;
    i_ccb_host.wr(OFS_BURST_ENABLE, 16'h0040, 1'b0);
    sc();
    // Function enable then burst, each with odd values between the commands
    for (i = 0; i < 12; i++)
    begin
      c8 = cmd[i % 6];
      i_ccb_host.wr(i < 6 ? OFS_FUNC_ENABLE : OFS_BURST_ENABLE, {8'h00, c8}, 1'b0);
      if (c8 == CMD_ON || c8 == CMD_OFF)
        {ef, eb} = i < 6 ? {c8[6], eb} : {ef, c8[6]};
      sc();
    end
    i_ccb_host.rd(OFS_FUNC_ENABLE, 1'b0, v);
    chk("write_only", 16'h0000, v);
    $display("test enables done");
    for (i = 0; i < 2; i++)
    begin
      jmp = 7'(i << 1);
      i_ccb_host.wr(OFS_CONV_DISABLE, 16'h0040, 1'b0);
      chk("fifo_reset", 16'(i == 0), 16'(fr));
    end
    ec = 1'b0;
    sc();
    i_ccb_host.wr(OFS_CONV_DISABLE, 16'h0000, 1'b0);
    ec = 1'b1;
    sc();
    $display("test conversions done");
    idx(IDX_GEN_CONFIG);
    i_ccb_host.rd(OFS_INDEX_DATA, 1'b0, v);
    chk("no_bank", 16'h0000, v);
    bank = 1'b1;
    for (i = 0; i < 20; i++)
    begin
      jmp = 7'($random(seed));
      v = 16'($random(seed));
      idx(IDX_IRQ_SELECT);
      i_ccb_host.wr(OFS_INDEX_DATA, v, 1'b1);
      c8 = v[7:0];
      idx(IDX_GEN_CONFIG);
      i_ccb_host.rd(OFS_INDEX_DATA, 1'b1, v);
      chk("gen_config", {9'h000, jmp}, v);
      i_ccb_host.rd(OFS_INDEX_DATA, 1'b0, v);
      chk("irq_select", {8'h00, c8}, v);
    end
    idx(IDX_GEN_CONFIG);
    i_ccb_host.wr(OFS_INDEX_DATA, 16'h00FF, 1'b0);
    chk("autoinc_off", 16'h0001, 16'(ai));
    idx(IDX_GEN_CONFIG);
    repeat (2)
    begin
      i_ccb_host.rd(OFS_INDEX_DATA, 1'b0, v);
      chk("index_hold", {8'h00, 1'b1, jmp}, v);
    end
    i_ccb_host.rd(OFS_INDEX_POINTER, 1'b0, v);
    chk("index_ptr", 16'h0000, v);
    i_ccb_host.wr(OFS_INDEX_DATA, 16'h0000, 1'b0);
    chk("autoinc_on", 16'h0000, 16'(ai));
    $display("test index done");
    for (i = 0; i < 2; i++)
    begin
      ten = i[0];
      idx(IDX_EXT_STATUS);
      i_ccb_host.rd(OFS_INDEX_DATA, 1'b0, v);
      chk("ten_bit", {8'h00, ten ? st() : 8'h00}, v);
    end
    idx(IDX_FUNC_ENABLE);
    i_ccb_host.wr(OFS_INDEX_DATA, 16'h0000, 1'b0);
    ef = 1'b0;
    sc();
    $display("test ten bit done");
    // Every source code on each half; codes that select nothing see every event
    for (i = 0; i < 32; i++)
    begin
      {c, s} = 5'(i);
      nz = c < 4'h2 || c == 4'h6 || c == 4'h7;
      idx(IDX_IRQ_SELECT);
      i_ccb_host.wr(OFS_INDEX_DATA, {8'h00, s ? {c, 4'h0} : {4'h0, c}}, 1'b0);
      ssbe = 1'($random(seed));
      ev.digital_in = {4{c[0]}};
      @(negedge ref_clk_in);
      e = {nz | c == 4'h2, nz | c == 4'h3, nz | c == 4'h4, nz | c == 4'h5, ev.digital_in};
      if (c[3])
        e.digital_in[c[2:1]] = ~c[0];
      ev = nz ? {e[7:4], ~e.digital_in} : e;
      @(negedge ref_clk_in);
      ev = {4'h0, ev.digital_in};
      chk("flag_a", 16'(!nz && !s && ssbe), 16'(fa));
      chk("flag_b", 16'(!nz && s && ssbe), 16'(fb));
    end
    $display("test sources done");
    // Reset in mid-run must drop both enables and allow conversions again
    srst_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    srst_in = 1'b0;
    {eb, ef, ec} = 3'b001;
    sc();
    $display("test reset done");
    print_verdict();
  end
endmodule

bind ccb_compat_config_bank ccb_chk i_ccb_chk (.ref_clk_in, .srst_in, .io_addr_in, .io_rd_in,
  .io_wr_in, .io_wr_data_in, .io_rd_data_out, .io_rd_valid_out, .jumpers_in,
  .burst_mode_enabled_out, .compat_functions_on_out, .conversions_allowed_out,
  .fifo_reset_out);
